// ---- hw/ccasf_defs.vh ----
// ccasf_defs.vh: constants of the 8-bit core datapath
// assumes: included by the core and its testbench, definitions only
`ifndef CCASF_DEFS_VH
`define CCASF_DEFS_VH
// data space map
`define CCASF_IO_BASE   16'h0020
`define CCASF_EXT_BASE  16'h0060
`define CCASF_STATUS_FLAGS_REG_IO   6'h3f
`define CCASF_SPL_IO    6'h3d
`define CCASF_SPH_IO    6'h3e
`define CCASF_STATUS_FLAGS_REG_RST  8'h00
`define CCASF_PC_RST    16'h0000
`define CCASF_VEC_STEP  16'h0002
// status bit positions
`define CCASF_FI 7
`define CCASF_FT 6
`define CCASF_FH 5
`define CCASF_FS 4
`define CCASF_FV 3
`define CCASF_FN 2
`define CCASF_FZ 1
`define CCASF_FC 0
// instruction fields
`define CCASF_OP   15:12
`define CCASF_RD   11:7
`define CCASF_RR   6:2
`define CCASF_RDI  11:8
`define CCASF_IMM  7:0
`define CCASF_BIT  6:4
`define CCASF_SUB  3:0
`define CCASF_DIR  11
`define CCASF_MRD  10:6
`define CCASF_IOA  5:0
`define CCASF_PTR  5:4
`define CCASF_LPM  3
// opcodes
`define CCASF_OP_ADD  4'h0
`define CCASF_OP_ADC  4'h1
`define CCASF_OP_SUB  4'h2
`define CCASF_OP_SBC  4'h3
`define CCASF_OP_AND  4'h4
`define CCASF_OP_OR   4'h5
`define CCASF_OP_EOR  4'h6
`define CCASF_OP_MOV  4'h7
`define CCASF_OP_SUBI 4'h8
`define CCASF_OP_ANDI 4'h9
`define CCASF_OP_ORI  4'ha
`define CCASF_OP_LDI  4'hb
`define CCASF_OP_MISC 4'hc
`define CCASF_OP_IO   4'hd
`define CCASF_OP_PTR  4'he
`define CCASF_OP_DIR  4'hf
// single-register and control sub-codes
`define CCASF_SU_COM  4'h0
`define CCASF_SU_NEG  4'h1
`define CCASF_SU_INC  4'h2
`define CCASF_SU_DEC  4'h3
`define CCASF_SU_LSR  4'h4
`define CCASF_SU_ROR  4'h5
`define CCASF_SU_BST  4'h6
`define CCASF_SU_BLD  4'h7
`define CCASF_SU_SEI  4'h8
`define CCASF_SU_CLI  4'h9
`define CCASF_SU_IRQ_RETURN_OP 4'ha
`define CCASF_SU_RET  4'hb
`define CCASF_SU_CALL 4'hc
`define CCASF_SU_JMP  4'hd
`define CCASF_SU_SPM  4'he
// pointer select
`define CCASF_PX 2'h0
`define CCASF_PY 2'h1
`endif

// ---- hw/ccasf_regfile.v ----
// ccasf_regfile.v: 32 x 8 working registers, two read ports, one write port
// assumes: reads are used in the same cycle, the write lands at the clock edge
`timescale 1ns/1ns
`default_nettype none
module ccasf_regfile #(
  parameter NREG = 32
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // operand reads
  input  wire [4:0]  ra_a,
  input  wire [4:0]  ra_b,
  output wire [7:0]  rd_a,
  output wire [7:0]  rd_b,
  // result write
  input  wire        we,
  input  wire [4:0]  wa,
  input  wire [7:0]  wd,
  // register pairs
  output wire [15:0] ptr_x,
  output wire [15:0] ptr_y,
  output wire [15:0] ptr_z,
  output wire [15:0] pair0
);
  reg [7:0] mem [0:NREG-1];
  integer   i;

  // reads stay combinational so fetch, compute and write-back fit one cycle
  assign rd_a  = mem[ra_a]; // RL1
  assign rd_b  = mem[ra_b]; // RL2
  assign ptr_x = {mem[27], mem[26]}; // RL4
  assign ptr_y = {mem[29], mem[28]}; // RL4
  assign ptr_z = {mem[31], mem[30]}; // RL4
  assign pair0 = {mem[1], mem[0]};

  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < NREG; i = i + 1) begin
        mem[i] <= 8'h00;
      end
    end else if (we) begin
      mem[wa] <= wd; // RL1
    end
  end
endmodule // ccasf_regfile
`default_nettype wire

// ---- hw/ccasf_core.v ----
// ccasf_core.v: 8-bit core datapath with alu, status flags and i/o mapping
// assumes: program and data memories answer one cycle after a registered request
// What this block does
// RL1: thirty-two byte registers, each read and written in one cycle
// RL2: two operands read, computed and written back in one cycle
// RL3: separate program and data buses, next word prefetched during execute
// RL4: three register pairs act as pointers, one also reads program memory
// RL5: decoder takes one-word and two-word instructions
// RL6: program store only acts when executed from the boot section
// RL7: call or taken interrupt pushes the return address on the stack
// RL8: each interrupt has its own vector, lowest vector served first
// RL9: sixty-four i/o locations also seen right after the register file
// RL10: i/o instructions use 0x00-0x3f, data access uses that plus 0x20
// RL11: space from 0x60 only reachable by data loads and stores
// RL12: alu does register, immediate and single-register operations
// RL13: flags updated after every alu operation
// RL14: software saves and restores the flags around interrupt service
// RL15: flags at i/o 0x3f, data 0x5f, read/write except bit 4 which is written as n xor v, reset 0x00
// RL16: bit 7 is global interrupt enable, clear blocks all interrupts
// RL17: enable cleared on interrupt entry, set on return, set/clear ops
// RL18: bit 6 copies a register bit in and out
// RL19: bit 5 holds the half carry for decimal arithmetic
// RL20: bit 4 always equals negative xor overflow
// RL21: bits 3 to 0 are overflow, negative, zero and carry
// RL22: half carry is the adder carry out of bit 3, inverted into a borrow for subtraction
`timescale 1ns/1ns
`default_nettype none
`include "ccasf_defs.vh"
module ccasf_core #(
  parameter        NIRQ       = 8,
  parameter [15:0] BOOT_START = 16'hf000,
  parameter [15:0] SP_RESET   = 16'h0000
) (
  // clock and reset
  input  wire            CLK,
  input  wire            RST_N,
  // program memory
  output wire [15:0]     PADDR,
  input  wire [15:0]     PDATA,
  output reg             PWE,
  output reg  [15:0]     PWADDR,
  output reg  [15:0]     PWDATA,
  // data memory from 0x60
  output reg  [15:0]     DADDR,
  output reg  [7:0]      DWDATA,
  output reg             DWE,
  output reg             DRE,
  input  wire [7:0]      DRDATA,
  // i/o register space
  output reg  [5:0]      IOADDR,
  output reg  [7:0]      IOWDATA,
  output reg             IOWE,
  output reg             IORE,
  input  wire [7:0]      IORDATA,
  // interrupts
  input  wire [NIRQ-1:0] IRQ_REQ,
  output reg  [NIRQ-1:0] IRQ_ACK,
  // status
  output wire [7:0]      STATUS_FLAGS
);
  localparam [10:0] S_EXEC  = 11'h001;
  localparam [10:0] S_WORD2 = 11'h002;
  localparam [10:0] S_MEM   = 11'h004;
  localparam [10:0] S_MWAIT = 11'h008;
  localparam [10:0] S_MCAP  = 11'h010;
  localparam [10:0] S_PUSH1 = 11'h020;
  localparam [10:0] S_PUSH2 = 11'h040;
  localparam [10:0] S_POP1  = 11'h080;
  localparam [10:0] S_POP2  = 11'h100;
  localparam [10:0] S_POP3  = 11'h200;
  localparam [10:0] S_POP4  = 11'h400;
  localparam [2:0]  M_ADD   = 3'h0;
  localparam [2:0]  M_INC   = 3'h1;
  localparam [2:0]  M_LOG   = 3'h2;
  localparam [2:0]  M_COM   = 3'h3;
  localparam [2:0]  M_SHR   = 3'h4;
  localparam [1:0]  SRC_D   = 2'h0;
  localparam [1:0]  SRC_IO  = 2'h1;
  localparam [1:0]  SRC_P   = 2'h2;

  reg  [15:0] pc;
  reg  [15:0] ex_pc;
  reg         fvalid;
  reg  [10:0] state;
  reg  [15:0] ir;
  reg  [7:0]  status_flags_reg;
  reg  [15:0] sp;
  reg  [15:0] maddr;
  reg  [1:0]  msrc;
  reg  [15:0] ret_pc;
  reg  [15:0] tgt;
  reg  [7:0]  alu_a;
  reg  [7:0]  alu_b;
  reg         alu_sub;
  reg         alu_cin;
  reg  [2:0]  mode;
  reg  [7:0]  lres;
  reg         alu_fw;
  reg         cp_wr;
  reg  [7:0]  cp_val;
  reg         rf_we;
  reg  [4:0]  rf_wa;
  reg  [7:0]  rf_wd;
  reg  [7:0]  int_rd;
  reg  [15:0] irq_idx;
  integer     i;
  wire [7:0]  rf_a;
  wire [7:0]  rf_b;
  wire [15:0] ptr_x;
  wire [15:0] ptr_y;
  wire [15:0] ptr_z;
  wire [15:0] pair0;

  // in execute the word on the program bus is the instruction itself
  wire [15:0] instr   = (state == S_EXEC) ? PDATA : ir; // RL3
  wire [3:0]  op      = instr[`CCASF_OP];
  wire [3:0]  sub     = instr[`CCASF_SUB];
  wire [2:0]  bsel    = instr[`CCASF_BIT];
  wire [7:0]  imm     = instr[`CCASF_IMM];
  wire        imm_op  = (op >= `CCASF_OP_SUBI) && (op <= `CCASF_OP_LDI);
  wire        mem_op  = (op >= `CCASF_OP_IO);
  wire [4:0]  dec_d   = imm_op ? {1'b1, instr[`CCASF_RDI]} :
                        mem_op ? instr[`CCASF_MRD] : instr[`CCASF_RD];
  wire [4:0]  ir_d    = ir[`CCASF_MRD];
  wire        irq_take = fvalid && status_flags_reg[`CCASF_FI] && (|IRQ_REQ); // RL16
  wire        exec_go = (state == S_EXEC) && fvalid && !irq_take;
  wire [15:0] io_off  = maddr - `CCASF_IO_BASE;
  wire [5:0]  io_a    = io_off[5:0];
  wire        in_rf   = (maddr < `CCASF_IO_BASE);
  wire        in_io   = !in_rf && (maddr < `CCASF_EXT_BASE); // RL9
  wire        io_int  = in_io && ((io_a == `CCASF_STATUS_FLAGS_REG_IO) ||
                        (io_a == `CCASF_SPL_IO) || (io_a == `CCASF_SPH_IO));
  wire [15:0] ptr_sel = (instr[`CCASF_PTR] == `CCASF_PX) ? ptr_x :
                        (instr[`CCASF_PTR] == `CCASF_PY) ? ptr_y : ptr_z; // RL4
  wire [7:0]  flag_in = {rf_a[7:5], rf_a[3] ^ rf_a[2], rf_a[3:0]}; // RL20
  wire [7:0]  cap_val = (msrc == SRC_IO) ? IORDATA : (msrc == SRC_D) ? DRDATA :
                        (ptr_z[0] ? PDATA[15:8] : PDATA[7:0]); // RL4

  // alu adder shared by add, subtract, negate, increment and decrement
  wire [7:0]  bb      = alu_sub ? ~alu_b : alu_b;
  wire [8:0]  sum     = {1'b0, alu_a} + {1'b0, bb} + {8'h00, alu_cin};
  wire [4:0]  half    = {1'b0, alu_a[3:0]} + {1'b0, bb[3:0]} + {4'h0, alu_cin};
  wire        arith   = (mode == M_ADD) || (mode == M_INC);
  wire [7:0]  res     = arith ? sum[7:0] : lres;
  wire        vf      = arith ? ((alu_a[7] == bb[7]) && (res[7] != alu_a[7])) :
                        (mode == M_SHR) ? (res[7] ^ rf_a[0]) : 1'b0; // RL21
  wire        cf      = (mode == M_ADD) ? (sum[8] ^ alu_sub) :
                        (mode == M_COM) ? 1'b1 :
                        (mode == M_SHR) ? rf_a[0] : status_flags_reg[`CCASF_FC]; // RL21
  wire        hf      = (mode == M_ADD) ? (half[4] ^ alu_sub) : status_flags_reg[`CCASF_FH]; // RL22
  wire [7:0]  alu_fl  = {status_flags_reg[7:6], hf, res[7] ^ vf, vf, res[7],
                        res == 8'h00, cf}; // RL19 RL20 RL21

  assign PADDR        = pc;
  assign STATUS_FLAGS = status_flags_reg;

  ccasf_regfile #(
    .NREG (32)
  ) u_rf (
    .clk   (CLK),
    .rst_n (RST_N),
    .ra_a  ((state == S_EXEC) ? dec_d : ir_d),
    .ra_b  ((state == S_EXEC) ? instr[`CCASF_RR] : maddr[4:0]),
    .rd_a  (rf_a),
    .rd_b  (rf_b),
    .we    (rf_we),
    .wa    (rf_wa),
    .wd    (rf_wd),
    .ptr_x (ptr_x),
    .ptr_y (ptr_y),
    .ptr_z (ptr_z),
    .pair0 (pair0)
  );

  // alu operand and mode selection
  always @* begin
    alu_a   = rf_a;
    alu_b   = (imm_op) ? imm : rf_b;
    alu_sub = 1'b0;
    alu_cin = 1'b0;
    mode    = M_ADD;
    lres    = 8'h00;
    alu_fw  = 1'b0;
    cp_wr   = 1'b0;
    cp_val  = imm;
    case (op) // RL12
      `CCASF_OP_ADD: alu_fw = 1'b1;
      `CCASF_OP_ADC: begin
        alu_fw  = 1'b1;
        alu_cin = status_flags_reg[`CCASF_FC];
      end
      `CCASF_OP_SUB, `CCASF_OP_SUBI: begin
        alu_fw  = 1'b1;
        alu_sub = 1'b1;
        alu_cin = 1'b1;
      end
      `CCASF_OP_SBC: begin
        alu_fw  = 1'b1;
        alu_sub = 1'b1;
        alu_cin = ~status_flags_reg[`CCASF_FC];
      end
      `CCASF_OP_AND, `CCASF_OP_ANDI: begin
        alu_fw = 1'b1;
        mode   = M_LOG;
        lres   = rf_a & alu_b;
      end
      `CCASF_OP_OR, `CCASF_OP_ORI: begin
        alu_fw = 1'b1;
        mode   = M_LOG;
        lres   = rf_a | alu_b;
      end
      `CCASF_OP_EOR: begin
        alu_fw = 1'b1;
        mode   = M_LOG;
        lres   = rf_a ^ rf_b;
      end
      `CCASF_OP_MOV: begin
        cp_wr  = 1'b1;
        cp_val = rf_b;
      end
      `CCASF_OP_LDI: cp_wr = 1'b1;
      `CCASF_OP_MISC: begin
        case (sub)
          `CCASF_SU_COM: begin
            alu_fw = 1'b1;
            mode   = M_COM;
            lres   = ~rf_a;
          end
          `CCASF_SU_NEG: begin
            alu_fw  = 1'b1;
            alu_a   = 8'h00;
            alu_b   = rf_a;
            alu_sub = 1'b1;
            alu_cin = 1'b1;
          end
          `CCASF_SU_INC, `CCASF_SU_DEC: begin
            alu_fw  = 1'b1;
            mode    = M_INC;
            alu_b   = 8'h01;
            alu_sub = (sub == `CCASF_SU_DEC);
            alu_cin = (sub == `CCASF_SU_DEC);
          end
          `CCASF_SU_LSR, `CCASF_SU_ROR: begin
            alu_fw = 1'b1;
            mode   = M_SHR;
            lres   = {(sub == `CCASF_SU_ROR) & status_flags_reg[`CCASF_FC], rf_a[7:1]};
          end
          `CCASF_SU_BLD: begin
            cp_wr  = 1'b1;
            cp_val = (rf_a & ~(8'h01 << bsel)) |
                     ({7'h00, status_flags_reg[`CCASF_FT]} << bsel); // RL18
          end
          default: cp_wr = 1'b0;
        endcase
      end
      default: alu_fw = 1'b0;
    endcase
  end

  // internal i/o reads and the single register-file write port
  always @* begin
    case (io_a)
      `CCASF_STATUS_FLAGS_REG_IO: int_rd = status_flags_reg; // RL15
      `CCASF_SPL_IO:  int_rd = sp[7:0];
      `CCASF_SPH_IO:  int_rd = sp[15:8];
      default:        int_rd = rf_b;
    endcase
    rf_we = 1'b0;
    rf_wa = ir_d;
    rf_wd = cap_val;
    if (exec_go) begin
      rf_we = alu_fw | cp_wr; // RL2
      rf_wa = dec_d;
      rf_wd = cp_wr ? cp_val : res;
    end else if (state == S_MEM) begin
      rf_we = ir[`CCASF_DIR] ? in_rf : (in_rf | io_int);
      rf_wa = ir[`CCASF_DIR] ? maddr[4:0] : ir_d;
      rf_wd = ir[`CCASF_DIR] ? rf_a : int_rd;
    end else if (state == S_MCAP) begin
      rf_we = 1'b1;
    end
  end

  // lowest pending index wins
  always @* begin
    irq_idx = 16'h0000;
    for (i = NIRQ - 1; i >= 0; i = i - 1) begin
      if (IRQ_REQ[i]) begin
        irq_idx = i[15:0]; // RL8
      end
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      pc      <= `CCASF_PC_RST;
      ex_pc   <= `CCASF_PC_RST;
      fvalid  <= 1'b0;
      state   <= S_EXEC;
      ir      <= 16'h0000;
      status_flags_reg    <= `CCASF_STATUS_FLAGS_REG_RST; // RL15
      sp      <= SP_RESET;
      maddr   <= 16'h0000;
      msrc    <= SRC_D;
      ret_pc  <= 16'h0000;
      tgt     <= 16'h0000;
      PWE     <= 1'b0;
      PWADDR  <= 16'h0000;
      PWDATA  <= 16'h0000;
      DADDR   <= 16'h0000;
      DWDATA  <= 8'h00;
      DWE     <= 1'b0;
      DRE     <= 1'b0;
      IOADDR  <= 6'h00;
      IOWDATA <= 8'h00;
      IOWE    <= 1'b0;
      IORE    <= 1'b0;
      IRQ_ACK <= {NIRQ{1'b0}};
    end else begin
      PWE     <= 1'b0;
      DWE     <= 1'b0;
      DRE     <= 1'b0;
      IOWE    <= 1'b0;
      IORE    <= 1'b0;
      IRQ_ACK <= {NIRQ{1'b0}};
      case (state)
        S_EXEC: begin
          if (!fvalid) begin
            ex_pc  <= pc;
            pc     <= pc + 16'h0001;
            fvalid <= 1'b1;
          end else if (irq_take) begin
            // the flags are not saved here; service code does that itself
            ret_pc <= ex_pc; // RL7 RL14
            tgt    <= (irq_idx + 16'h0001) * `CCASF_VEC_STEP; // RL8
            status_flags_reg[`CCASF_FI] <= 1'b0; // RL17
            IRQ_ACK <= IRQ_REQ & ~(IRQ_REQ - {{(NIRQ-1){1'b0}}, 1'b1}); // RL8
            fvalid <= 1'b0;
            pc     <= ex_pc;
            state  <= S_PUSH1;
          end else begin
            ir     <= PDATA;
            ex_pc  <= pc; // RL3
            pc     <= pc + 16'h0001;
            if (alu_fw) begin
              status_flags_reg <= alu_fl; // RL13
            end
            if (op == `CCASF_OP_MISC) begin
              case (sub)
                `CCASF_SU_BST:  status_flags_reg[`CCASF_FT] <= rf_a[bsel]; // RL18
                `CCASF_SU_SEI:  status_flags_reg[`CCASF_FI] <= 1'b1; // RL17
                `CCASF_SU_CLI:  status_flags_reg[`CCASF_FI] <= 1'b0; // RL17
                `CCASF_SU_IRQ_RETURN_OP, `CCASF_SU_RET: begin
                  fvalid <= 1'b0;
                  state  <= S_POP1;
                end
                `CCASF_SU_CALL, `CCASF_SU_JMP: begin
                  // the word after the pushes is stale, so refetch at the target
                  pc     <= pc; // RL5
                  fvalid <= 1'b0;
                  state  <= S_WORD2;
                end
                `CCASF_SU_SPM: begin
                  // a store from outside the boot section is dropped silently
                  PWE    <= (ex_pc >= BOOT_START); // RL6
                  PWADDR <= ptr_z;
                  PWDATA <= pair0;
                end
                default: fvalid <= 1'b1;
              endcase
            end else if (mem_op) begin
              pc     <= pc;
              fvalid <= 1'b0;
              if (op == `CCASF_OP_IO) begin
                maddr <= {10'h000, instr[`CCASF_IOA]} + `CCASF_IO_BASE; // RL10 RL11
                state <= S_MEM;
              end else if (op == `CCASF_OP_DIR) begin
                state <= S_WORD2; // RL5
              end else if (instr[`CCASF_LPM]) begin
                pc    <= {1'b0, ptr_z[15:1]}; // RL4
                msrc  <= SRC_P;
                state <= S_MWAIT;
              end else begin
                maddr <= ptr_sel; // RL4
                state <= S_MEM;
              end
            end
          end
        end
        S_WORD2: begin
          if (ir[`CCASF_OP] == `CCASF_OP_DIR) begin
            maddr <= PDATA; // RL5
            pc    <= pc + 16'h0001;
            state <= S_MEM;
          end else if (ir[`CCASF_SUB] == `CCASF_SU_CALL) begin
            tgt    <= PDATA;
            ret_pc <= pc + 16'h0001; // RL7
            state  <= S_PUSH1;
          end else begin
            pc     <= PDATA;
            fvalid <= 1'b0;
            state  <= S_EXEC;
          end
        end
        S_MEM: begin
          state <= S_EXEC;
          if (in_io && !io_int) begin
            IOADDR  <= io_a; // RL9
            IOWDATA <= rf_a;
            IOWE    <= ir[`CCASF_DIR];
            IORE    <= !ir[`CCASF_DIR];
            msrc    <= SRC_IO;
            state   <= ir[`CCASF_DIR] ? S_EXEC : S_MWAIT;
          end else if (!in_rf && !in_io) begin
            DADDR  <= maddr; // RL11
            DWDATA <= rf_a;
            DWE    <= ir[`CCASF_DIR];
            DRE    <= !ir[`CCASF_DIR];
            msrc   <= SRC_D;
            state  <= ir[`CCASF_DIR] ? S_EXEC : S_MWAIT;
          end else if (io_int && ir[`CCASF_DIR]) begin
            if (io_a == `CCASF_STATUS_FLAGS_REG_IO) begin
              status_flags_reg <= flag_in; // RL15 RL20
            end else if (io_a == `CCASF_SPL_IO) begin
              sp[7:0] <= rf_a;
            end else begin
              sp[15:8] <= rf_a;
            end
          end
        end
        S_MWAIT: state <= S_MCAP;
        S_MCAP: begin
          if (msrc == SRC_P) begin
            pc <= ex_pc;
          end
          state <= S_EXEC;
        end
        S_PUSH1: begin
          DADDR  <= sp; // RL7
          DWDATA <= ret_pc[7:0];
          DWE    <= 1'b1;
          sp     <= sp - 16'h0001;
          state  <= S_PUSH2;
        end
        S_PUSH2: begin
          DADDR  <= sp; // RL7
          DWDATA <= ret_pc[15:8];
          DWE    <= 1'b1;
          sp     <= sp - 16'h0001;
          pc     <= tgt;
          state  <= S_EXEC;
        end
        S_POP1, S_POP2: begin
          DADDR <= sp + 16'h0001;
          DRE   <= 1'b1;
          sp    <= sp + 16'h0001;
          state <= (state == S_POP1) ? S_POP2 : S_POP3;
        end
        S_POP3: begin
          ret_pc[15:8] <= DRDATA;
          state        <= S_POP4;
        end
        S_POP4: begin
          pc <= {ret_pc[15:8], DRDATA};
          if (ir[`CCASF_SUB] == `CCASF_SU_IRQ_RETURN_OP) begin
            status_flags_reg[`CCASF_FI] <= 1'b1; // RL17
          end
          state <= S_EXEC;
        end
        default: state <= S_EXEC;
      endcase
    end
  end
endmodule // ccasf_core
`default_nettype wire

// ---- verif/ccasf_core_assertions.sv ----
// ccasf_core_assertions.sv: port checks on the core
// assumes: bound to every ccasf_core instance
`timescale 1ns/1ns
`default_nettype none
module ccasf_core_chk #(
  parameter NIRQ = 8
) (
  // clock and reset
  input wire logic            CLK,
  input wire logic            RST_N,
  // buses
  input wire logic [15:0]     PADDR,
  input wire logic [15:0]     DADDR,
  input wire logic            DWE,
  input wire logic            DRE,
  input wire logic [5:0]      IOADDR,
  input wire logic            IOWE,
  // interrupts and flags
  input wire logic [NIRQ-1:0] IRQ_REQ,
  input wire logic [NIRQ-1:0] IRQ_ACK,
  input wire logic [7:0]      STATUS_FLAGS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  reset_clear_a: assert property ($rose(RST_N) |-> STATUS_FLAGS == 8'h00 && PADDR == 16'h0000)
    else $error("flags or pc not cleared by reset");
  sign_xor_a: assert property (STATUS_FLAGS[4] == (STATUS_FLAGS[2] ^ STATUS_FLAGS[3]))
    else $error("sign flag not n xor v");
  irq_gate_a: assert property (IRQ_ACK != '0 |-> $past(STATUS_FLAGS[7]))
    else $error("interrupt taken while disabled");
  irq_prio_a: assert property (IRQ_ACK != '0 |-> IRQ_ACK == ($past(IRQ_REQ) & (~$past(IRQ_REQ) + 1'b1)))
    else $error("interrupt priority wrong");
  irq_clear_a: assert property (IRQ_ACK != '0 |-> !STATUS_FLAGS[7])
    else $error("enable not cleared on entry");
  ack_pulse_a: assert property (IRQ_ACK != '0 |=> IRQ_ACK == '0)
    else $error("ack longer than one cycle");
  io_status_a: assert property (IOWE |-> IOADDR != 6'h3f)
    else $error("status register leaked to i/o bus");
  io_pulse_a: assert property (IOWE |=> !IOWE)
    else $error("i/o write not a pulse");
  ext_space_a: assert property (DWE || DRE |-> DADDR < 16'h0020 || DADDR > 16'h005f)
    else $error("i/o range sent to data bus");
  bus_single_a: assert property (DWE |-> !IOWE && !DRE)
    else $error("two accesses at once");
endmodule // ccasf_core_chk
bind ccasf_core ccasf_core_chk #(.NIRQ(NIRQ)) u_chk (.CLK(CLK), .RST_N(RST_N), .PADDR(PADDR),
  .DADDR(DADDR), .DWE(DWE), .DRE(DRE), .IOADDR(IOADDR), .IOWE(IOWE), .IRQ_REQ(IRQ_REQ),
  .IRQ_ACK(IRQ_ACK), .STATUS_FLAGS(STATUS_FLAGS));
`default_nettype wire

// ---- verif/ccasf_mem_model.sv ----
// ccasf_mem_model.sv: program, data and i/o memories facing the core
// assumes: each answer one cycle after the registered request
`timescale 1ns/1ns
`default_nettype none
module ccasf_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // program bus
  input  wire logic [15:0] paddr,
  output var  logic [15:0] pdata,
  // data bus
  input  wire logic [15:0] daddr,
  input  wire logic [7:0]  dwdata,
  input  wire logic        dwe,
  input  wire logic        dre,
  output var  logic [7:0]  drdata,
  // i/o bus
  input  wire logic [5:0]  ioaddr,
  input  wire logic [7:0]  iowdata,
  input  wire logic        iowe,
  input  wire logic        iore,
  output var  logic [7:0]  iordata
);
  logic [15:0] pmem [0:255];
  logic [7:0]  dmem [0:255];
  logic [7:0]  io   [0:63];
  logic        mark;
  initial begin
    pdata = 16'h0000;
    drdata = 8'h00;
    iordata = 8'h00;
    mark = 1'b0;
  end
  // idle read lines toggle so a stale value is never mistaken for data
  always @(posedge clk) begin
    pdata <= pmem[paddr[7:0]];
    drdata <= dre ? dmem[daddr[7:0]] : ~drdata;
    iordata <= iore ? io[ioaddr] : ~iordata;
    if (dwe) dmem[daddr[7:0]] <= dwdata;
    if (iowe) io[ioaddr] <= iowdata;
    mark <= rst_n & (mark | (iowe & (ioaddr == 6'h01)));
  end
endmodule // ccasf_mem_model
`default_nettype wire

// ---- verif/ccasf_core_tb.sv ----
// ccasf_core_tb.sv: short programs, random and corner, run on the core
// assumes: memories preloaded through hierarchy just before each reset pulse
`timescale 1ns/1ns
`default_nettype none
`include "ccasf_defs.vh"
module ccasf_core_tb;
  logic        clk, rst_n, dwe, dre, iowe, iore, pwe, pwe_seen;
  logic [7:0]  irq_req, irq_ack, ack_seen, flags, dwdata, drdata, iowdata, iordata;
  logic [15:0] paddr, pdata, daddr;
  logic [5:0]  ioaddr;
  logic [15:0] prog [$];
  logic [3:0]  ops [5] = '{`CCASF_OP_ADD, `CCASF_OP_SUB, `CCASF_OP_AND, `CCASF_OP_OR, `CCASF_OP_EOR};
  logic [7:0]  ca [4] = '{8'h7f, 8'h80, 8'h0f, 8'h00};
  logic [7:0]  cb [4] = '{8'h01, 8'h80, 8'h01, 8'h00};
  integer      num_errors, checks_done;
  ccasf_core DUT (.CLK(clk), .RST_N(rst_n), .PADDR(paddr), .PDATA(pdata), .PWE(pwe), .PWADDR(),
    .PWDATA(), .DADDR(daddr), .DWDATA(dwdata), .DWE(dwe), .DRE(dre), .DRDATA(drdata),
    .IOADDR(ioaddr), .IOWDATA(iowdata), .IOWE(iowe), .IORE(iore), .IORDATA(iordata),
    .IRQ_REQ(irq_req), .IRQ_ACK(irq_ack), .STATUS_FLAGS(flags));
  ccasf_mem_model u_mem (.clk(clk), .rst_n(rst_n), .paddr(paddr), .pdata(pdata), .daddr(daddr),
    .dwdata(dwdata), .dwe(dwe), .dre(dre), .drdata(drdata), .ioaddr(ioaddr), .iowdata(iowdata),
    .iowe(iowe), .iore(iore), .iordata(iordata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) ack_seen <= rst_n ? (ack_seen | irq_ack) : 8'h00;
  always @(posedge clk) pwe_seen <= rst_n ? (pwe_seen | pwe) : 1'b0;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // each program ends with an i/o write to 0x01, the partner flags it
  task automatic run(input logic [7:0] req);
    integer i;
    for (i = 0; i < 256; i++) u_mem.pmem[i] = (i < prog.size()) ? prog[i] : 16'hc00f;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk(flags, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    irq_req <= req;
    for (i = 0; i < 200 && u_mem.mark !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (u_mem.mark !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    irq_req <= 8'h00;
  endtask
  function automatic logic [15:0] alu(input logic [3:0] op, input logic [7:0] a, b);
    logic [8:0] s;
    logic       h, v;
    h = 1'b0;
    v = 1'b0;
    case (op)
      `CCASF_OP_ADD: begin
        s = a + b;
        h = ({1'b0, a[3:0]} + b[3:0]) > 5'h0f;
        v = (a[7] == b[7]) && (s[7] != a[7]);
      end
      `CCASF_OP_SUB: begin
        s = {1'b0, a} - {1'b0, b};
        h = a[3:0] < b[3:0];
        v = (a[7] != b[7]) && (s[7] != a[7]);
      end
      `CCASF_OP_AND: s = {1'b0, a & b};
      `CCASF_OP_OR: s = {1'b0, a | b};
      default: s = {1'b0, a ^ b};
    endcase
    return {s[7:0], 2'b00, h, s[7] ^ v, v, s[7], s[7:0] == 8'h00, s[8]};
  endfunction
  initial begin
    integer k, n;
    logic [7:0]  a, b, v, m;
    logic [15:0] e;
    rst_n = 1'b0;
    irq_req = 8'h00;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(32'hfc2b));
    for (k = 0; k < 5; k++) begin
      for (n = 0; n < 8; n++) begin
        a = (n < 4) ? ca[n] : 8'($urandom);
        b = (n < 4) ? cb[n] : 8'($urandom);
        prog = '{{4'hb, 4'h0, a}, {4'hb, 4'h1, b}, {ops[k], 5'd16, 5'd17, 2'b00},
          {4'hd, 1'b1, 5'd16, 6'h01}};
        run(8'($urandom) | 8'h01);
        e = alu(ops[k], a, b);
        // carry and half carry of logic ops are left open, so masked
        m = (ops[k] < 4'h4) ? 8'hff : 8'h1e;
        chk(u_mem.io[1], e[15:8]);
        chk(flags & m, e[7:0] & m);
        chk(ack_seen, 8'h00);
      end
    end
    v = 8'($urandom);
    u_mem.io[6'h3f] = 8'ha5;
    prog = '{16'hb0ff, {4'hd, 1'b1, 5'd16, 6'h3f}, 16'hc009, {4'hb, 4'h1, v},
      {4'hf, 1'b1, 5'd17, 6'h00}, 16'h0030, {4'hf, 1'b1, 5'd17, 6'h00}, 16'h0060,
      {4'hd, 1'b1, 5'd17, 6'h01}};
    run(8'h00);
    chk(flags, 8'h6f);
    chk(u_mem.io[6'h3f], 8'ha5);
    chk(u_mem.io[6'h10], v);
    chk(u_mem.dmem[8'h60], v);
    // program store from address 0 lies outside the boot section and must be dropped
    prog = '{16'hc00e, 16'hc008, 16'hc00f, 16'hc00f, 16'hc00f, 16'hc00f, {4'hd, 1'b1, 5'd0, 6'h01}};
    run(8'h0c);
    chk(ack_seen, 8'h04);
    chk(flags[7], 1'b0);
    chk(flags & 8'h7f, 8'h00);
    chk(pwe_seen, 1'b0);
    end_sim();
  end
endmodule // ccasf_core_tb
`default_nettype wire
